/* src/supervision_map.svh */
`ifndef SUPERVISION_MAP_SVH
`define SUPERVISION_MAP_SVH

// System clock rate and counter widths.
`define CLK_MHZ         100
`define TMR_W           25
`define CAL_W           14
`define EDGE_W          11

// Supervision times in microseconds, as nominal figures.
`define WDT_TIMEOUT_US  310000
`define RETRY_00_US     150000
`define RETRY_01_US     75000
`define RETRY_10_US     37500
`define RETRY_11_US     17700
`define LONG_LOW_US     250000

// Internal oscillator and calibration pulse limits.
`define PWM_DEFAULT_HZ  400
`define CAL_MIN_NS      1500
`define CAL_MAX_NS      100000
`define CAL_MULT        32
`define CAL_TOL_PCT     10

// External clock monitor window and thresholds.
`define EXT_WINDOW_US   1000
`define EXT_FAST_KHZ    730
`define EXT_SLOW_KHZ    7

// Diagnostic duty limits in percent: off-state max, on-state min, short max.
`define DUTY_1K_H_OFF   62
`define DUTY_1K_H_ON    35
`define DUTY_1K_H_SH    90
`define DUTY_400_M_OFF  81
`define DUTY_400_M_ON   21
`define DUTY_400_M_SH   88
`define DUTY_400_H_OFF  84
`define DUTY_400_H_ON   14
`define DUTY_400_H_SH   95
`define DUTY_200_L_OFF  86
`define DUTY_200_L_ON   15
`define DUTY_200_L_SH   93
`define DUTY_200_M_OFF  90
`define DUTY_200_M_ON   11
`define DUTY_200_M_SH   94
`define DUTY_100_L_OFF  93
`define DUTY_100_L_ON   8
`define DUTY_100_L_SH   96

// Reset image of the pin synchroniser {in1, in0, select, reset line}.
`define PIN_SYNC_RST    4'hE

`endif

/* src/supervision_pkg.sv */
`include "supervision_map.svh"
`default_nettype none
package supervision_pkg;

	typedef logic [`TMR_W-1:0] count_type;

	typedef enum logic [1:0] {
		SLEW_MED  = 2'h0,
		SLEW_LOW  = 2'h1,
		SLEW_HIGH = 2'h2,
		SLEW_RSVD = 2'h3
	} slew_type;

	typedef enum logic [1:0] {
		BAND_1K  = 2'h0,
		BAND_400 = 2'h1,
		BAND_200 = 2'h2,
		BAND_100 = 2'h3
	} band_type;

	typedef enum logic [1:0] {
		CAL_WAIT = 2'h0,
		CAL_MEAS = 2'h1,
		CAL_EVAL = 2'h3
	} cal_state_type;

endpackage
`default_nettype wire

/* src/level_sync.sv */
`default_nettype none
module level_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] meta;

	// Two flip-flops; only the second stage is visible outside.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= RST_VAL;
			q_o  <= RST_VAL;
		end else if (ce_i) begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule
`default_nettype wire

/* src/hold_timer.sv */
`default_nettype none
module hold_timer
	import supervision_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	input  wire logic      ce_i,
	input  wire logic      run_i,
	input  wire logic      clr_i,
	input  wire count_type limit_i,
	output var  logic      done_o
);
	count_type cnt;
	logic      at_end;

	// A limit lowered mid-count still ends the period at once.
	assign at_end = (cnt >= (limit_i - count_type'(1)));

	// Counts run cycles; clear wins, the last cycle wraps to zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt    <= '0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= run_i & ~clr_i & at_end;
			if (clr_i | (run_i & at_end))
				cnt <= '0;
			else if (run_i)
				cnt <= cnt + count_type'(1);
		end
	end
endmodule
`default_nettype wire

/* src/switch_supervision_timers.sv */
// Summary of operation
// - Lost SPI contact enters fail-safe after the 310 ms watchdog timeout.
// - Watchdog runs only while the disable bit is zero, its reset value.
// - Timeout counts from the reset line's rising edge.
// - Retry period follows the 2-bit code: 150, 75, 37.5, 17.7 ms.
// - A direct input low for 250 ms unlatches faults or requests sleep.
// - Uncalibrated oscillator gives a 400 Hz PWM period.
// - Calibrated PWM period stays within ten percent of its target.
// - External clock above 730 kHz is flagged too fast.
// - External clock below 7 kHz is flagged too slow.
// - Holding inputs low is allowed with reset high; reset low means sleep.
// - Basic protections stay active whatever the duty or frequency.
// - At 1 kHz high slew, diagnostics follow 62, 35 and 90 percent limits.
// - At 400 Hz medium slew, diagnostics follow 81, 21 and 88 percent.
// - Edge rate code 00 medium, 01 low, 10 high.
`include "supervision_map.svh"
`default_nettype none
module switch_supervision_timers
	import supervision_pkg::*;
#(
	parameter int WDT_CYCLES      = `WDT_TIMEOUT_US * `CLK_MHZ,
	parameter int RETRY_00_CYCLES = `RETRY_00_US * `CLK_MHZ,
	// Shorter retry periods keep their ratio to the code 00 period.
	parameter int RETRY_01_CYCLES = int'(longint'(RETRY_00_CYCLES) *
		`RETRY_01_US / `RETRY_00_US),
	parameter int RETRY_10_CYCLES = int'(longint'(RETRY_00_CYCLES) *
		`RETRY_10_US / `RETRY_00_US),
	parameter int RETRY_11_CYCLES = int'(longint'(RETRY_00_CYCLES) *
		`RETRY_11_US / `RETRY_00_US),
	parameter int LONG_LOW_CYCLES = `LONG_LOW_US * `CLK_MHZ,
	parameter int PWM_DEF_CYCLES  = `CLK_MHZ * 1000000 / `PWM_DEFAULT_HZ,
	parameter int CAL_MAX_CYCLES  = `CAL_MAX_NS * `CLK_MHZ / 1000,
	parameter int EXT_WIN_CYCLES  = `EXT_WINDOW_US * `CLK_MHZ
) (
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic       ext_pwm_clk_i,
	input  wire logic       reset_line_low_i,
	input  wire logic       select_line_low_i,
	input  wire logic [1:0] in_line_i,
	input  wire logic       spi_txn_i,
	input  wire logic       watchdog_disable_bit_i,
	input  wire logic       retry_en_i,
	input  wire logic [1:0] retry_code_i,
	input  wire logic [1:0] edge_rate_code_i,
	input  wire logic [1:0] pwm_band_i,
	input  wire logic [6:0] duty_pct_i,
	input  wire logic       overcurrent_fault_i,
	input  wire logic       short_circuit_fault_i,
	input  wire logic       undervoltage_fault_i,
	input  wire logic       supply_high_fault_i,
	input  wire logic       thermal_fault_i,
	output var  logic       fail_safe_o,
	output var  logic       retry_tick_o,
	output var  logic [1:0] unlatch_o,
	output var  logic       sleep_req_o,
	output var  logic       pwm_tick_o,
	output var  logic       cal_done_o,
	output var  logic       ext_too_fast_o,
	output var  logic       ext_too_slow_o,
	output var  logic       protect_trip_o,
	output var  logic       open_load_off_check_o,
	output var  logic       open_load_on_check_o,
	output var  logic       shorted_output_check_o
);
	localparam int CAL_MIN_CYCLES = (`CAL_MIN_NS * `CLK_MHZ + 999) / 1000;
	localparam int FAST_EDGES =
		`EXT_FAST_KHZ * EXT_WIN_CYCLES / (`CLK_MHZ * 1000);
	localparam int SLOW_EDGES =
		`EXT_SLOW_KHZ * EXT_WIN_CYCLES / (`CLK_MHZ * 1000);

	// Retry period count for a given interval code.
	function automatic count_type retry_limit(input logic [1:0] code);
		case (code)
		2'h0:    retry_limit = count_type'(RETRY_00_CYCLES);
		2'h1:    retry_limit = count_type'(RETRY_01_CYCLES);
		2'h2:    retry_limit = count_type'(RETRY_10_CYCLES);
		default: retry_limit = count_type'(RETRY_11_CYCLES);
		endcase
	endfunction

	// Availability {off-state open load, on-state open load, short check}.
	function automatic logic [2:0] diag_ok(input logic [6:0] duty,
		input int off_max, input int on_min, input int sh_max);
		diag_ok = {duty <= 7'(off_max), duty >= 7'(on_min),
			duty <= 7'(sh_max)};
	endfunction

	logic [3:0]              pin_s;
	logic                    rst_high;
	logic                    sel_s;
	logic [1:0]              in_s;
	logic                    wdt_clr;
	logic                    wdt_run;
	logic                    wdt_done;
	logic [`TMR_W:0]         idle_cyc;
	logic [1:0]              retry_code_q;
	logic                    retry_clr;
	logic                    retry_done;
	count_type               retry_lim;
	count_type               retry_gap;
	logic [1:0]              ll_done;
	logic [1:0]              ll_fired;
	cal_state_type           cal_state;
	cal_state_type           next_cal_state;
	logic [`CAL_W-1:0]       cal_width;
	logic                    cal_ok;
	logic                    cal_load;
	count_type               pwm_period;
	logic                    osc_done;
	logic                    ext_rst;
	logic                    ext_toggle;
	logic                    tog_s;
	logic                    tog_d;
	logic                    ext_edge;
	logic                    win_done;
	logic [`EDGE_W-1:0]      edge_cnt;
	slew_type                slew;
	band_type                band;
	logic [2:0]              diag_1k_h;
	logic [2:0]              diag_400_m;
	logic [2:0]              diag_400_h;
	logic [2:0]              diag_200_l;
	logic [2:0]              diag_200_m;
	logic [2:0]              diag_100_l;
	logic [2:0]              diag_sel;

	// Pin levels from outside the clock domain pass two flip-flops first.
	level_sync #(.W(4), .RST_VAL(`PIN_SYNC_RST)) u_pin_sync (
		.clk_i (mclk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   ({in_line_i, select_line_low_i, reset_line_low_i}),
		.q_o   (pin_s)
	);

	assign rst_high = pin_s[0];
	assign sel_s    = pin_s[1];
	assign in_s     = pin_s[3:2];

	assign wdt_clr = spi_txn_i | ~rst_high | watchdog_disable_bit_i;
	assign wdt_run = ~fail_safe_o;

	hold_timer u_wdt (
		.clk_i   (mclk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.run_i   (wdt_run),
		.clr_i   (wdt_clr),
		.limit_i (count_type'(WDT_CYCLES)),
		.done_o  (wdt_done)
	);

	always_ff @(posedge mclk_i) begin
		if (rst_i)
			fail_safe_o <= 1'b0;
		else if (ce_i)
			fail_safe_o <= wdt_done | (fail_safe_o & rst_high);
	end

	// Quiet time seen by the watchdog, read only by the checks below.
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			idle_cyc <= '0;
		else if (ce_i & wdt_clr)
			idle_cyc <= '0;
		else if (ce_i & wdt_run)
			idle_cyc <= idle_cyc + (`TMR_W+1)'(1);
	end

	AST_WDT_TIMEOUT:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(fail_safe_o) |-> idle_cyc == (`TMR_W+1)'(WDT_CYCLES + 1))
		else $error("fail-safe entered at the wrong quiet time");

	AST_WDT_OFF:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && watchdog_disable_bit_i && $past(watchdog_disable_bit_i)
		&& !fail_safe_o |=> !fail_safe_o)
		else $error("fail-safe entered with the watchdog disabled");

	AST_WDT_RESET_LOW:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && !rst_high && $past(!rst_high) |=> !fail_safe_o)
		else $error("fail-safe held while the reset line is low");

	AST_WDT_KICK:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && spi_txn_i |=> !wdt_done)
		else $error("watchdog expired right after SPI traffic");

	assign retry_lim = retry_limit(retry_code_i);
	assign retry_clr = ~retry_en_i | (retry_code_i != retry_code_q);

	hold_timer u_retry (
		.clk_i   (mclk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.run_i   (1'b1),
		.clr_i   (retry_clr),
		.limit_i (retry_lim),
		.done_o  (retry_done)
	);

	// Retry tick, code history and the period gap seen by the check.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			retry_tick_o <= 1'b0;
			retry_code_q <= 2'h0;
			retry_gap    <= '0;
		end else if (ce_i) begin
			retry_tick_o <= retry_done;
			retry_code_q <= retry_code_i;
			retry_gap    <= retry_clr ? '0 : retry_done ?
				count_type'(1) : retry_gap + count_type'(1);
		end
	end

	AST_RETRY_PERIOD:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		retry_done |-> retry_gap == $past(retry_lim))
		else $error("retry period does not match its code");

	for (genvar ch = 0; ch < 2; ch++) begin : g_long_low
		hold_timer u_long_low (
			.clk_i   (mclk_i),
			.rst_i   (rst_i),
			.ce_i    (ce_i),
			.run_i   (~in_s[ch] & ~ll_fired[ch]),
			.clr_i   (in_s[ch]),
			.limit_i (count_type'(LONG_LOW_CYCLES)),
			.done_o  (ll_done[ch])
		);
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ll_fired    <= 2'h0;
			unlatch_o   <= 2'h0;
			sleep_req_o <= 1'b0;
		end else if (ce_i) begin
			ll_fired    <= (ll_fired | ll_done) & ~in_s;
			unlatch_o   <= ll_done & {2{rst_high}};
			sleep_req_o <= ((|ll_done) & ~rst_high) |
				(sleep_req_o & ~rst_high & ~(|in_s));
		end
	end

	AST_SLEEP_RESET_LOW:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(sleep_req_o) |-> $past(!rst_high) && $past(|ll_done))
		else $error("sleep requested without a long low under reset");

	// Calibration pulse measurement sequence.
	always_comb begin
		next_cal_state = cal_state;
		case (cal_state)
		CAL_WAIT: if (!sel_s) next_cal_state = CAL_MEAS;
		CAL_MEAS: if (sel_s) next_cal_state = CAL_EVAL;
		CAL_EVAL: next_cal_state = CAL_WAIT;
		default:  next_cal_state = CAL_WAIT;
		endcase
	end

	assign cal_ok = (cal_state == CAL_EVAL) &&
		(cal_width >= `CAL_W'(CAL_MIN_CYCLES)) &&
		(cal_width <= `CAL_W'(CAL_MAX_CYCLES));

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cal_state  <= CAL_WAIT;
			cal_width  <= '0;
			cal_load   <= 1'b0;
			cal_done_o <= 1'b0;
			pwm_period <= count_type'(PWM_DEF_CYCLES);
		end else if (ce_i) begin
			cal_state <= next_cal_state;
			cal_load  <= cal_ok;
			if (cal_state == CAL_WAIT)
				cal_width <= '0;
			else if (cal_state == CAL_MEAS && !sel_s && !(&cal_width))
				cal_width <= cal_width + `CAL_W'(1);
			if (cal_ok) begin
				pwm_period <= count_type'(cal_width * `CAL_MULT);
				cal_done_o <= 1'b1;
			end
		end
	end

	// A new period restarts the oscillator so the first tick is clean.
	hold_timer u_osc (
		.clk_i   (mclk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.run_i   (1'b1),
		.clr_i   (cal_load),
		.limit_i (pwm_period),
		.done_o  (osc_done)
	);

	// PWM clock tick from the internal oscillator.
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			pwm_tick_o <= 1'b0;
		else if (ce_i)
			pwm_tick_o <= osc_done;
	end

	AST_PWM_DEFAULT:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		!cal_done_o |-> pwm_period == count_type'(PWM_DEF_CYCLES))
		else $error("uncalibrated period differs from the default");

	AST_CAL_ACCURACY:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		cal_load |-> (100 * int'(pwm_period) <= (100 + `CAL_TOL_PCT) *
		int'($past(cal_width)) * `CAL_MULT) && (100 * int'(pwm_period) >=
		(100 - `CAL_TOL_PCT) * int'($past(cal_width)) * `CAL_MULT))
		else $error("calibrated period outside tolerance");

	// Reset level carried into the external clock domain.
	level_sync #(.W(1), .RST_VAL(1'b1)) u_ext_rst (
		.clk_i (ext_pwm_clk_i),
		.rst_i (1'b0),
		.ce_i  (1'b1),
		.d_i   (rst_i),
		.q_o   (ext_rst)
	);

	// One toggle per rising external clock edge; a stopped clock just stops it.
	always_ff @(posedge ext_pwm_clk_i) begin
		if (ext_rst)
			ext_toggle <= 1'b0;
		else
			ext_toggle <= ~ext_toggle;
	end

	level_sync #(.W(1), .RST_VAL(1'b0)) u_tog_sync (
		.clk_i (mclk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   (ext_toggle),
		.q_o   (tog_s)
	);

	assign ext_edge = tog_s ^ tog_d;

	hold_timer u_win (
		.clk_i   (mclk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.run_i   (1'b1),
		.clr_i   (1'b0),
		.limit_i (count_type'(EXT_WIN_CYCLES)),
		.done_o  (win_done)
	);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			tog_d          <= 1'b0;
			edge_cnt       <= '0;
			ext_too_fast_o <= 1'b0;
			ext_too_slow_o <= 1'b0;
		end else if (ce_i) begin
			tog_d <= tog_s;
			if (win_done) begin
				ext_too_fast_o <= edge_cnt > `EDGE_W'(FAST_EDGES);
				ext_too_slow_o <= edge_cnt < `EDGE_W'(SLOW_EDGES);
				edge_cnt       <= {{(`EDGE_W-1){1'b0}}, ext_edge};
			end else if (ext_edge && !(&edge_cnt)) begin
				edge_cnt <= edge_cnt + `EDGE_W'(1);
			end
		end
	end

	AST_EXT_FAST:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && win_done && edge_cnt > `EDGE_W'(FAST_EDGES)
		|=> ext_too_fast_o)
		else $error("fast external clock not flagged");

	AST_EXT_SLOW:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && win_done |=> ext_too_slow_o ==
		($past(edge_cnt) < `EDGE_W'(SLOW_EDGES)))
		else $error("slow external clock flag wrong");

	assign slew = slew_type'(edge_rate_code_i);
	assign band = band_type'(pwm_band_i);

	assign diag_1k_h  = diag_ok(duty_pct_i, `DUTY_1K_H_OFF,
		`DUTY_1K_H_ON, `DUTY_1K_H_SH);
	assign diag_400_m = diag_ok(duty_pct_i, `DUTY_400_M_OFF,
		`DUTY_400_M_ON, `DUTY_400_M_SH);
	assign diag_400_h = diag_ok(duty_pct_i, `DUTY_400_H_OFF,
		`DUTY_400_H_ON, `DUTY_400_H_SH);
	assign diag_200_l = diag_ok(duty_pct_i, `DUTY_200_L_OFF,
		`DUTY_200_L_ON, `DUTY_200_L_SH);
	assign diag_200_m = diag_ok(duty_pct_i, `DUTY_200_M_OFF,
		`DUTY_200_M_ON, `DUTY_200_M_SH);
	assign diag_100_l = diag_ok(duty_pct_i, `DUTY_100_L_OFF,
		`DUTY_100_L_ON, `DUTY_100_L_SH);

	// Unlisted band and edge rate pairs report the diagnostics unavailable.
	assign diag_sel =
		(band == BAND_1K  && slew == SLEW_HIGH) ? diag_1k_h  :
		(band == BAND_400 && slew == SLEW_MED)  ? diag_400_m :
		(band == BAND_400 && slew == SLEW_HIGH) ? diag_400_h :
		(band == BAND_200 && slew == SLEW_LOW)  ? diag_200_l :
		(band == BAND_200 && slew == SLEW_MED)  ? diag_200_m :
		(band == BAND_100 && slew == SLEW_LOW)  ? diag_100_l : 3'h0;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			protect_trip_o         <= 1'b0;
			open_load_off_check_o  <= 1'b0;
			open_load_on_check_o   <= 1'b0;
			shorted_output_check_o <= 1'b0;
		end else if (ce_i) begin
			protect_trip_o <= overcurrent_fault_i | short_circuit_fault_i |
				undervoltage_fault_i | supply_high_fault_i | thermal_fault_i;
			open_load_off_check_o  <= diag_sel[2];
			open_load_on_check_o   <= diag_sel[1];
			shorted_output_check_o <= diag_sel[0];
		end
	end

	AST_PROTECT_ALWAYS:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && (overcurrent_fault_i || thermal_fault_i ||
		short_circuit_fault_i) |=> protect_trip_o)
		else $error("protection fault not passed through");

	AST_DIAG_1K_HIGH:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && band == BAND_1K && slew == SLEW_HIGH &&
		duty_pct_i == 7'h3F |=> !open_load_off_check_o &&
		open_load_on_check_o && shorted_output_check_o)
		else $error("1 kHz high slew availability wrong at 63 percent");

	AST_DIAG_400_MED:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && band == BAND_400 && slew == SLEW_MED &&
		duty_pct_i == 7'h14 |=> open_load_off_check_o &&
		!open_load_on_check_o && shorted_output_check_o)
		else $error("400 Hz medium slew availability wrong at 20 percent");

	AST_SLEW_LOW:
	assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && edge_rate_code_i == 2'h1 && band == BAND_200 &&
		duty_pct_i == 7'h57 |=> !open_load_off_check_o)
		else $error("edge rate code 01 not decoded as low slew");

endmodule
`default_nettype wire

/* sim/host_model.sv */
`default_nettype none
module host_model (
	input  wire logic mclk_i,
	input  wire logic ext_run_i,
	output var  logic select_line_low_o,
	output var  logic ext_pwm_clk_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Select idles high and the external clock starts parked low.
	initial begin
		select_line_low_o = 1'b1;
		ext_pwm_clk_o = 1'b0;
	end

	// external clock rate
	// Runs far above the recommended range on purpose, so the monitor
	// must flag it, and stands low while stopped to look too slow.
	always #7.5 ext_pwm_clk_o = ext_run_i ? ~ext_pwm_clk_o : 1'b0;

	// calibration pulse width
	// Holds select low for the given number of clock cycles.
	task automatic cal_pulse(input int width);
		@(posedge mclk_i);
		#1;
		select_line_low_o = 1'b0;
		repeat (width) @(posedge mclk_i);
		#1;
		select_line_low_o = 1'b1;
	endtask
endmodule
`default_nettype wire

/* sim/switch_supervision_timers_test.sv */
`default_nettype none
module switch_supervision_timers_test;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int WDT  = 2000;
	localparam int LOWN = 300;
	localparam int RT   = 400;

	logic       mclk       = 1'b0;
	logic       rst        = 1'b1;
	logic       ce         = 1'b1;
	logic       ext_run    = 1'b1;
	logic       rst_line_n = 1'b1;
	logic [1:0] in_line    = 2'h3;
	logic       spi        = 1'b0;
	logic       watchdog_disable_bit     = 1'b0;
	logic       retry_en   = 1'b0;
	logic [1:0] retry_code = 2'h0;
	logic [1:0] edge_code  = 2'h0;
	logic [1:0] band       = 2'h0;
	logic [6:0] duty       = 7'h0;
	logic [4:0] faults     = 5'h0;
	logic       ext_clk;
	logic       sel;
	logic       fail_safe, retry_tick, sleep_req, pwm_tick, cal_done;
	logic       fast, slow, trip, off_ok, on_ok, sh_ok;
	logic [1:0] unlatch;
	logic [2:0] ev;
	int         n_mismatch = 0;
	int         checked    = 0;

	// Pulses that the gap measurement can wait on.
	assign ev = {unlatch[0], pwm_tick, retry_tick};

	// Free-running system clock.
	always #5 mclk = ~mclk;

	host_model i_host_model (
		.mclk_i           (mclk),
		.ext_run_i        (ext_run),
		.select_line_low_o(sel),
		.ext_pwm_clk_o    (ext_clk)
	);

	switch_supervision_timers #(
		.WDT_CYCLES     (WDT),
		.RETRY_00_CYCLES(RT),
		.LONG_LOW_CYCLES(LOWN),
		.PWM_DEF_CYCLES (500),
		.EXT_WIN_CYCLES (20000)
	) i_switch_supervision_timers (
		.mclk_i                (mclk),
		.rst_i                 (rst),
		.ce_i                  (ce),
		.ext_pwm_clk_i         (ext_clk),
		.reset_line_low_i      (rst_line_n),
		.select_line_low_i     (sel),
		.in_line_i             (in_line),
		.spi_txn_i             (spi),
		.watchdog_disable_bit_i(watchdog_disable_bit),
		.retry_en_i            (retry_en),
		.retry_code_i          (retry_code),
		.edge_rate_code_i      (edge_code),
		.pwm_band_i            (band),
		.duty_pct_i            (duty),
		.overcurrent_fault_i   (faults[0]),
		.short_circuit_fault_i (faults[1]),
		.undervoltage_fault_i  (faults[2]),
		.supply_high_fault_i   (faults[3]),
		.thermal_fault_i       (faults[4]),
		.fail_safe_o           (fail_safe),
		.retry_tick_o          (retry_tick),
		.unlatch_o             (unlatch),
		.sleep_req_o           (sleep_req),
		.pwm_tick_o            (pwm_tick),
		.cal_done_o            (cal_done),
		.ext_too_fast_o        (fast),
		.ext_too_slow_o        (slow),
		.protect_trip_o        (trip),
		.open_load_off_check_o (off_ok),
		.open_load_on_check_o  (on_ok),
		.shorted_output_check_o(sh_ok)
	);

	// Compares one value and reports a difference at once.
	task automatic check(input string what, input logic [31:0] got,
		input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Steps whole cycles and lands just after the edge.
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Counts cycles until the chosen pulse shows, up to a limit.
	task automatic wait_for(input int k, input int lim, output int n);
		n = 0;
		do begin
			tick(1);
			n++;
		end while (ev[k] !== 1'b1 && n < lim);
	endtask

	// Timeout after the last transaction, restart by the reset line,
	// and silence while the disable bit is set.
	task automatic t_watchdog();
		tick(5);
		spi = 1'b1;
		tick(1);
		spi = 1'b0;
		tick(WDT);
		check("fail_safe early", fail_safe, 0);
		tick(1);
		check("fail_safe", fail_safe, 1);
		rst_line_n = 1'b0;
		tick(4);
		check("fail_safe cleared", fail_safe, 0);
		rst_line_n = 1'b1;
		tick(WDT);
		check("fail_safe restart", fail_safe, 0);
		tick(8);
		check("fail_safe again", fail_safe, 1);
		rst_line_n = 1'b0;
		watchdog_disable_bit = 1'b1;
		tick(4);
		rst_line_n = 1'b1;
		tick(WDT + 50);
		check("fail_safe disabled", fail_safe, 0);
	endtask

	// Measures the retry period for every interval code.
	task automatic t_retry();
		int rl[4] = '{RT, RT / 2, RT / 4, RT * 177 / 1500};
		int n;
		for (int c = 0; c < 4; c++) begin
			retry_code = 2'(c);
			retry_en = 1'b1;
			wait_for(0, 1000, n);
			wait_for(0, 1000, n);
			check("retry period", n, rl[c]);
			retry_en = 1'b0;
			tick(2);
		end
	endtask

	// Default period, a rejected short pulse, then a real calibration.
	task automatic t_osc_cal();
		int n;
		wait_for(1, 1000, n);
		wait_for(1, 1000, n);
		check("default period", n, 500);
		i_host_model.cal_pulse(100);
		tick(5);
		check("cal short", cal_done, 0);
		i_host_model.cal_pulse(200);
		tick(5);
		check("cal done", cal_done, 1);
		wait_for(1, 8000, n);
		wait_for(1, 8000, n);
		check("cal period", n >= 5760 && n <= 7040, 1);
	endtask

	// Long low unlatches with the reset line high, else requests sleep.
	task automatic t_long_low();
		int n;
		in_line = 2'h0;
		wait_for(2, 400, n);
		check("unlatch delay", n >= LOWN && n <= LOWN + 6, 1);
		check("unlatch both", unlatch, 3);
		in_line = 2'h3;
		tick(3);
		rst_line_n = 1'b0;
		in_line = 2'h0;
		tick(LOWN + 10);
		check("sleep", sleep_req, 1);
		in_line = 2'h3;
		tick(4);
		check("sleep released", sleep_req, 0);
		rst_line_n = 1'b1;
	endtask

	// Diagnostic windows at their duty edges for each slew code, then
	// protection, frozen with the clock enable low, then each fault in turn.
	task automatic t_diag();
		int dt[14][4] = '{'{0, 2, 62, 7}, '{0, 2, 63, 3}, '{0, 2, 34, 5},
			'{0, 2, 91, 2}, '{1, 0, 81, 7}, '{1, 0, 82, 3}, '{1, 0, 20, 5},
			'{1, 0, 89, 2}, '{2, 1, 86, 7}, '{2, 1, 87, 3}, '{3, 3, 50, 0},
			'{1, 2, 84, 7}, '{2, 0, 90, 7}, '{3, 1, 7, 5}};
		for (int i = 0; i < 14; i++) begin
			band = 2'(dt[i][0]);
			edge_code = 2'(dt[i][1]);
			duty = 7'(dt[i][2]);
			tick(3);
			check("diag", {29'h0, off_ok, on_ok, sh_ok}, dt[i][3]);
		end
		ce = 1'b0;
		faults = 5'h1;
		tick(3);
		check("trip frozen", trip, 0);
		ce = 1'b1;
		tick(2);
		check("trip resumed", trip, 1);
		faults = 5'h0;
		tick(3);
		for (int k = 0; k < 5; k++) begin
			faults = 5'h1 << k;
			tick(3);
			check("trip", trip, 1);
			faults = 5'h0;
			tick(3);
			check("trip clear", trip, 0);
		end
	endtask

	// External clock runs fast, then stops.
	task automatic t_ext();
		tick(25000);
		check("ext fast", {fast, slow}, 2);
		ext_run = 1'b0;
		tick(45000);
		check("ext slow", {fast, slow}, 1);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Main sequence: reset, then the monitor beside the other scenarios.
	initial begin
		tick(12);
		rst = 1'b0;
		fork
			t_ext();
			begin
				t_watchdog();
				t_retry();
				t_osc_cal();
				t_long_low();
				t_diag();
			end
		join
		finish_test();
	end

	// Cuts a hang short well past the expected run length.
	initial begin
		tick(90000);
		n_mismatch++;
		finish_test();
	end
endmodule
`default_nettype wire
